// File: sfp_pkg.sv
/*
  Shared constants for the switch fault protection block: register map, field
  positions, reset values and timing counts. Assumes a 100 MHz system clock.
*/
package sfp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ = 100;
  // short-circuit deglitch, a least time, rounded up
  localparam int DEGLITCH_NS = 2000;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  // one microsecond tick for the hold-off timer
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] DG_MAX = 8'(DEGLITCH_CYC);
  localparam logic [6:0] TICK_MAX = 7'(TICK_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // register word addresses
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_HOLDOFF = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h3;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;

  // control and reset values
  localparam int CTRL_REGULATE = 0;
  localparam logic [15:0] HOLDOFF_RST = 16'h03e8;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // interrupt status bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_UVLO = 1;
  localparam int IRQ_FOLD = 2;
  localparam int IRQ_REV = 3;

  // foldback after this many consecutive shutdowns
  localparam logic [1:0] FOLD_LIMIT = 2'h3;

  typedef enum logic [1:0] {
    SFP_OFF,
    SFP_ON,
    SFP_FAULT
  } sfp_state_e;

endpackage : sfp_pkg

// File: sfp_prot_if.sv
/*
  Carrier between the fault controller and its retry timer and foldback
  counter. Assumes all three share one clock and synchronous reset.
*/
`timescale 1ns/1ps
interface sfp_prot_if (
  input wire logic clk,
  input wire logic rst
);
  logic retry_start;
  logic retry_expired;
  logic [15:0] holdoff_us;
  logic shutdown;
  logic fold_clear;
  logic fold_half;
  logic [1:0] fold_count;

  modport ctrl (output retry_start, holdoff_us, shutdown, fold_clear,
    input retry_expired, fold_half, fold_count);
  modport timer (input clk, rst, retry_start, holdoff_us, output retry_expired);
  modport fold (input clk, rst, shutdown, fold_clear, output fold_half, fold_count);
endinterface : sfp_prot_if

// File: sfp_retry_timer.sv
/*
  Retry hold-off timer: counts the programmed number of microseconds after
  each fault shutdown. Assumes retry_start is a one-cycle pulse.
*/
`timescale 1ns/1ps
module sfp_retry_timer (
  sfp_prot_if.timer p
);
  logic [6:0] tick_cnt;
  logic [15:0] us_left;
  logic expired;
  logic [6:0] next_tick_cnt;
  logic [15:0] next_us_left;
  logic next_expired;
  logic tick;

  assign p.retry_expired = expired;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    tick = (tick_cnt == sfp_pkg::TICK_MAX);
    next_tick_cnt = tick ? 7'h00 : tick_cnt + 7'h01;
    next_us_left = us_left;
    next_expired = expired;
    if (p.retry_start) begin
      // restart the tick so a hold-off never runs short by a partial tick
      next_tick_cnt = 7'h00;
      next_us_left = p.holdoff_us;
      next_expired = (p.holdoff_us == 16'h0000);
    end else if (!expired && tick) begin
      next_us_left = us_left - 16'h0001;
      next_expired = (us_left == 16'h0001);
    end
  end

  always_ff @(posedge p.clk) begin
    if (p.rst) begin
      tick_cnt <= 7'h00;
      us_left <= 16'h0000;
      expired <= 1'b1;
    end else begin
      tick_cnt <= next_tick_cnt;
      us_left <= next_us_left;
      expired <= next_expired;
    end
  end

  a_timer_restart: assert property (@(posedge p.clk) disable iff (p.rst)
    p.retry_start && p.holdoff_us != 16'h0000 |=> !p.retry_expired)
    else $error("hold-off did not restart on shutdown");

endmodule : sfp_retry_timer

// File: sfp_foldback.sv
/*
  Foldback counter: counts consecutive fault shutdowns and halves the current
  limit at the third. Assumes shutdown and fold_clear are one-cycle pulses.
*/
`timescale 1ns/1ps
module sfp_foldback (
  sfp_prot_if.fold p
);
  logic [1:0] count;
  logic half;
  logic [1:0] next_count;
  logic next_half;

  assign p.fold_count = count;
  assign p.fold_half = half;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_count = p.fold_clear ? 2'h0 : count;
    if (p.shutdown && next_count != sfp_pkg::FOLD_LIMIT) begin
      next_count = next_count + 2'h1;
    end
    next_half = (next_count == sfp_pkg::FOLD_LIMIT);
  end

  always_ff @(posedge p.clk) begin
    if (p.rst) begin
      count <= 2'h0;
      half <= 1'b0;
    end else begin
      count <= next_count;
      half <= next_half;
    end
  end

  a_fold_three: assert property (@(posedge p.clk) disable iff (p.rst)
    p.shutdown && !p.fold_clear && count == 2'h2 |=> half)
    else $error("limit not halved after third shutdown");
  a_fold_restore: assert property (@(posedge p.clk) disable iff (p.rst)
    p.fold_clear && !p.shutdown |=> !half && count == 2'h0)
    else $error("limit not restored");

endmodule : sfp_foldback

// File: sfp_fault_ctrl.sv
/*
  Fault handling control for a single-channel high-side switch, with an
  Avalon-MM register slave and one level interrupt. Assumes every detection
  input is already synchronous to CLK and reads as a clean level.
*/
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module sfp_fault_ctrl (
  input wire logic CLK,
  input wire logic RST,
  input wire logic ENABLE,
  input wire logic LATCH,
  input wire logic SELECT_BIT_TWO_GROUNDED,
  input wire logic TEMP_ABOVE_TRIP,
  input wire logic TEMP_BELOW_HYSTERESIS,
  input wire logic CURRENT_AT_LIMIT,
  input wire logic ENERGY_LIMIT_REACHED,
  input wire logic SUPPLY_AT_FALL_THRESHOLD,
  input wire logic SUPPLY_AT_RISE_THRESHOLD,
  input wire logic REVERSE_BATTERY,
  input wire logic LOAD_DUMP,
  input wire logic STANDBY_DELAY,
  input wire logic OUTPUT_VOLTAGE_RISEN,
  input wire logic [2:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic SWITCH_ON,
  output logic CURRENT_LIMIT_HALF,
  output logic CURRENT_REGULATE,
  output logic ANALOG_SENSE_OUTPUT_FAULT,
  output logic FAULT_STATUS_N_OUT,
  output logic FAULT_STATUS_N_OE_N,
  output logic IRQ
);
  sfp_pkg::sfp_state_e state, next_state;
  logic en_hold, uv, thermal, curr, energy, rev_q, st_fault, sense_fault;
  logic next_en_hold, next_uv, next_thermal, next_curr, next_energy;
  logic next_st_fault, next_sense_fault, next_sw, next_reg;
  logic [7:0] dg_cnt, next_dg_cnt;
  logic regulate, next_regulate;
  logic [15:0] holdoff, next_holdoff;
  logic [sfp_pkg::IRQ_W-1:0] irq_stat, irq_mask, next_irq_stat, next_irq_mask, ev;
  logic ack, next_ack, acc_rd, acc_wr, next_irq;
  logic [31:0] next_rdata;
  logic rev_ok, sc_det, any_fault, trip, release_ok;

  sfp_prot_if pif (.clk(CLK), .rst(RST));
  sfp_retry_timer u_timer (.p(pif.timer));
  sfp_foldback u_fold (.p(pif.fold));

  ////////////////////////////////////////////////////////////////////////////
  // fault detection
  always_comb begin
    rev_ok = REVERSE_BATTERY && SELECT_BIT_TWO_GROUNDED;
    sc_det = (dg_cnt == sfp_pkg::DG_MAX);
    any_fault = thermal || curr || energy;
    trip = (state == sfp_pkg::SFP_ON) && any_fault && !rev_ok;
    release_ok = !LATCH && pif.retry_expired && !any_fault;
    // load dump freezes the sampled enable
    next_en_hold = LOAD_DUMP ? en_hold : ENABLE;
    next_uv = SUPPLY_AT_FALL_THRESHOLD || (uv && !SUPPLY_AT_RISE_THRESHOLD);
    next_dg_cnt = 8'h00;
    if (CURRENT_AT_LIMIT) begin
      next_dg_cnt = sc_det ? dg_cnt : dg_cnt + 8'h01;
    end
    // protection is switched off under reverse battery
    if (rev_ok) begin
      next_thermal = 1'b0;
      next_curr = 1'b0;
      next_energy = 1'b0;
    end else begin
      next_thermal = TEMP_ABOVE_TRIP || (thermal && !TEMP_BELOW_HYSTERESIS);
      // a current that drops in the last deglitch cycle is not taken as a short
      next_curr = (sc_det && CURRENT_AT_LIMIT && !regulate) || (curr && CURRENT_AT_LIMIT);
      next_energy = ENERGY_LIMIT_REACHED;
    end
  end

  // flags are registered so the state machine never sees a half-settled input
  always_ff @(posedge CLK) begin
    if (RST) begin
      en_hold <= 1'b0;
      uv <= 1'b1;
      dg_cnt <= 8'h00;
      thermal <= 1'b0;
      curr <= 1'b0;
      energy <= 1'b0;
    end else begin
      en_hold <= next_en_hold;
      uv <= next_uv;
      dg_cnt <= next_dg_cnt;
      thermal <= next_thermal;
      curr <= next_curr;
      energy <= next_energy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switch state
  always_comb begin
    next_state = state;
    case (state)
      sfp_pkg::SFP_OFF: begin
        if (en_hold && !uv) begin
          next_state = sfp_pkg::SFP_ON;
        end
      end
      sfp_pkg::SFP_ON: begin
        if (trip) begin
          next_state = sfp_pkg::SFP_FAULT;
        end else if (!en_hold || uv) begin
          next_state = sfp_pkg::SFP_OFF;
        end
      end
      sfp_pkg::SFP_FAULT: begin
        if (release_ok) begin
          next_state = (en_hold && !uv) ? sfp_pkg::SFP_ON : sfp_pkg::SFP_OFF;
        end
      end
      default: next_state = sfp_pkg::SFP_OFF;
    endcase
    next_sw = rev_ok || (next_state == sfp_pkg::SFP_ON && !next_uv);
    next_reg = regulate && sc_det && state == sfp_pkg::SFP_ON && !rev_ok;
    next_st_fault = (next_state == sfp_pkg::SFP_FAULT);
    // sense fault lingers on retry until the output has come up
    next_sense_fault = next_st_fault || (sense_fault && !OUTPUT_VOLTAGE_RISEN
      && next_state == sfp_pkg::SFP_ON);
    pif.retry_start = trip;
    pif.shutdown = trip;
    // a trip leaves on for fault, so any on-to-off step is a clean cycle
    pif.fold_clear = STANDBY_DELAY || (state == sfp_pkg::SFP_ON
      && next_state == sfp_pkg::SFP_OFF);
    pif.holdoff_us = holdoff;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= sfp_pkg::SFP_OFF;
      rev_q <= 1'b0;
      SWITCH_ON <= 1'b0;
      CURRENT_REGULATE <= 1'b0;
      st_fault <= 1'b0;
      sense_fault <= 1'b0;
    end else begin
      state <= next_state;
      rev_q <= rev_ok;
      SWITCH_ON <= next_sw;
      CURRENT_REGULATE <= next_reg;
      st_fault <= next_st_fault;
      sense_fault <= next_sense_fault;
    end
  end

  // open drain: pulled low only while in fault
  assign FAULT_STATUS_N_OUT = 1'b0;
  assign FAULT_STATUS_N_OE_N = !st_fault;
  assign ANALOG_SENSE_OUTPUT_FAULT = sense_fault;
  assign CURRENT_LIMIT_HALF = pif.fold_half;

  ////////////////////////////////////////////////////////////////////////////
  // register slave, one wait state on every access
  always_comb begin
    AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
    next_ack = (AVS_READ || AVS_WRITE) && !ack;
    acc_rd = AVS_READ && ack;
    acc_wr = AVS_WRITE && ack;
    next_rdata = AVS_READDATA;
    if (AVS_READ && !ack) begin
      case (AVS_ADDRESS)
        sfp_pkg::ADDR_CTRL: next_rdata = {31'h0, regulate};
        sfp_pkg::ADDR_HOLDOFF: next_rdata = {16'h0, holdoff};
        sfp_pkg::ADDR_STATUS: next_rdata = {22'h0, pif.fold_count, SWITCH_ON,
          rev_q, pif.fold_half, uv, energy, curr, thermal,
          state == sfp_pkg::SFP_FAULT};
        sfp_pkg::ADDR_IRQ_STAT: next_rdata = {28'h0, irq_stat};
        sfp_pkg::ADDR_IRQ_MASK: next_rdata = {28'h0, irq_mask};
        default: next_rdata = 32'h0;
      endcase
    end
    next_regulate = regulate;
    next_holdoff = holdoff;
    next_irq_mask = irq_mask;
    if (acc_wr && AVS_ADDRESS == sfp_pkg::ADDR_CTRL) begin
      next_regulate = AVS_WRITEDATA[sfp_pkg::CTRL_REGULATE];
    end
    if (acc_wr && AVS_ADDRESS == sfp_pkg::ADDR_HOLDOFF) begin
      next_holdoff = AVS_WRITEDATA[15:0];
    end
    if (acc_wr && AVS_ADDRESS == sfp_pkg::ADDR_IRQ_MASK) begin
      next_irq_mask = AVS_WRITEDATA[sfp_pkg::IRQ_W-1:0];
    end
    ev = '0;
    ev[sfp_pkg::IRQ_FAULT] = trip;
    ev[sfp_pkg::IRQ_UVLO] = next_uv && !uv;
    ev[sfp_pkg::IRQ_FOLD] = trip && !pif.fold_clear && pif.fold_count == 2'h2;
    // edged so a long reverse period raises one event only
    ev[sfp_pkg::IRQ_REV] = rev_ok && !rev_q;
    // only bits already returned are cleared; a new event always survives
    next_irq_stat = irq_stat | ev;
    if (acc_rd && AVS_ADDRESS == sfp_pkg::ADDR_IRQ_STAT) begin
      next_irq_stat = (irq_stat & ~AVS_READDATA[sfp_pkg::IRQ_W-1:0]) | ev;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ack <= 1'b0;
      AVS_READDATA <= 32'h0;
      regulate <= 1'b0;
      holdoff <= sfp_pkg::HOLDOFF_RST;
      irq_stat <= '0;
      irq_mask <= sfp_pkg::IRQ_MASK_RST;
      IRQ <= 1'b0;
    end else begin
      ack <= next_ack;
      AVS_READDATA <= next_rdata;
      regulate <= next_regulate;
      holdoff <= next_holdoff;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      IRQ <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  a_trip_to_fault: assert property (trip |=> state == sfp_pkg::SFP_FAULT)
    else $error("shutdown did not enter fault");
  a_fault_both_pins: assert property (
    state == sfp_pkg::SFP_FAULT |-> !FAULT_STATUS_N_OE_N && ANALOG_SENSE_OUTPUT_FAULT)
    else $error("fault not shown on both outputs");
  a_release_gated: assert property (
    $past(state) == sfp_pkg::SFP_FAULT && state != sfp_pkg::SFP_FAULT
    |-> $past(!LATCH && pif.retry_expired && !any_fault))
    else $error("fault released too early");
  a_thermal_hyst: assert property (
    thermal && !TEMP_BELOW_HYSTERESIS && !rev_ok |=> thermal)
    else $error("thermal fault cleared before hysteresis");
  a_current_off: assert property (
    sc_det && !regulate && !rev_ok && state == sfp_pkg::SFP_ON && CURRENT_AT_LIMIT
    ##1 !rev_ok && state == sfp_pkg::SFP_ON |=> state == sfp_pkg::SFP_FAULT)
    else $error("immediate-off mode did not shut down");
  a_deglitch_len: assert property (
    $rose(curr) |-> $past(CURRENT_AT_LIMIT && dg_cnt == sfp_pkg::DG_MAX))
    else $error("short circuit taken before deglitch");
  a_uv_off: assert property (uv && !$past(rev_ok) |-> !SWITCH_ON)
    else $error("switch on during undervoltage");
  a_load_dump: assert property (LOAD_DUMP |=> en_hold == $past(en_hold))
    else $error("enable changed during load dump");
  a_reverse_on: assert property (rev_ok |=> SWITCH_ON)
    else $error("reverse battery did not turn switch on");
  a_retry_pin: assert property (
    $past(state) == sfp_pkg::SFP_FAULT && state == sfp_pkg::SFP_ON |-> FAULT_STATUS_N_OE_N)
    else $error("status pin held after retry");

  // supply, regulation and retry details
  a_energy_holds: assert property (
    state == sfp_pkg::SFP_FAULT && energy |=> state == sfp_pkg::SFP_FAULT)
    else $error("released while energy limit active");
  a_uv_resume: assert property (
    state == sfp_pkg::SFP_OFF && en_hold && !uv |=> state == sfp_pkg::SFP_ON)
    else $error("switch did not resume above lockout");
  a_sense_linger: assert property (
    $past(state) == sfp_pkg::SFP_FAULT && state == sfp_pkg::SFP_ON
    && !$past(OUTPUT_VOLTAGE_RISEN) |-> ANALOG_SENSE_OUTPUT_FAULT)
    else $error("sense fault dropped before output rose");
  a_regulate_on: assert property (
    CURRENT_REGULATE |-> $past(regulate) && $past(state) == sfp_pkg::SFP_ON)
    else $error("regulating outside on state");
  a_fold_clean: assert property (
    state == sfp_pkg::SFP_ON && !trip && (!en_hold || uv) |=> !CURRENT_LIMIT_HALF)
    else $error("clean off did not restore limit");
  a_rev_no_prot: assert property (rev_ok |=> !thermal && !curr && !energy)
    else $error("protection active under reverse battery");

  c_fault: cover property (trip);
  c_retry: cover property (state == sfp_pkg::SFP_FAULT ##1 state == sfp_pkg::SFP_ON);
  c_fold: cover property ($rose(CURRENT_LIMIT_HALF));
  c_irq_read: cover property (acc_rd && AVS_ADDRESS == sfp_pkg::ADDR_IRQ_STAT && IRQ);
  c_uv_lockout: cover property ($rose(uv));

endmodule : sfp_fault_ctrl

// File: sfp_host_model.sv
/*
  Host controller model for the fault protection block: drives enable and
  latch from the bench's wishes. Assumes one clock and synchronous reset.
*/
`timescale 1ns/1ps
module sfp_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic want_enable,
  input wire logic want_latch,
  input wire logic supply_up,
  output logic enable,
  output logic latch
);
  ////////////////////////////////////////////////////////////////////////////
  // a slow ramp could glitch the switch, so enable waits for a proven supply
  logic ramp_done;
  always_ff @(posedge clk) begin
    if (rst) begin
      ramp_done <= 1'b0;
      enable <= 1'b0;
      latch <= 1'b1;
    end else begin
      if (supply_up) begin
        ramp_done <= 1'b1;
      end
      enable <= want_enable & ramp_done;
      latch <= want_latch;
    end
  end
endmodule : sfp_host_model

// File: test_sfp_fault_ctrl.sv
/*
  Self-checking bench for the fault controller: scenario tasks, an
  Avalon-MM master task and a host model. Assumes a 100 MHz clock.
*/
`timescale 1ns/1ps
module test_sfp_fault_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en_want = 1'b0, latch_want = 1'b1, select_bit_two = 1'b0, t_hi = 1'b0, t_hys = 1'b0;
  logic cur = 1'b0, nrg = 1'b0, uv_f = 1'b0, uv_r = 1'b1, rev = 1'b0, ld = 1'b0;
  logic stby = 1'b0, output_voltage = 1'b0, enable, latch;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic waitreq, sw_on, half, regul, sense, st_out, st_oe_n, irq;
  wire st_n = st_oe_n ? 1'b1 : st_out; // pull-up on the status line
  int failures = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  sfp_host_model i_host (.clk(clk), .rst(rst), .want_enable(en_want),
    .want_latch(latch_want), .supply_up(uv_r), .enable(enable), .latch(latch));

  sfp_fault_ctrl i_dut (.CLK(clk), .RST(rst), .ENABLE(enable), .LATCH(latch),
    .SELECT_BIT_TWO_GROUNDED(select_bit_two), .TEMP_ABOVE_TRIP(t_hi), .TEMP_BELOW_HYSTERESIS(t_hys),
    .CURRENT_AT_LIMIT(cur), .ENERGY_LIMIT_REACHED(nrg), .SUPPLY_AT_FALL_THRESHOLD(uv_f),
    .SUPPLY_AT_RISE_THRESHOLD(uv_r), .REVERSE_BATTERY(rev), .LOAD_DUMP(ld),
    .STANDBY_DELAY(stby), .OUTPUT_VOLTAGE_RISEN(output_voltage), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(waitreq), .SWITCH_ON(sw_on),
    .CURRENT_LIMIT_HALF(half), .CURRENT_REGULATE(regul), .ANALOG_SENSE_OUTPUT_FAULT(sense),
    .FAULT_STATUS_N_OUT(st_out), .FAULT_STATUS_N_OE_N(st_oe_n), .IRQ(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle

  // one bus cycle; the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (waitreq !== 1'b0) begin
      failures++;
      $display("Error t=%0t waitrequest=%h exp=%h", $time, waitreq, 1'b0);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic conclude();
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(1'b0, 3'h1, 32'h0); chk(rd, 32'h000003e8);
    bus(1'b0, 3'h4, 32'h0); chk(rd, 32'h0);
    bus(1'b0, 3'h0, 32'h0); chk(rd, 32'h0);
    bus(1'b1, 3'h5, 32'hffffffff);
    bus(1'b0, 3'h5, 32'h0); chk(rd, 32'h0);
    bus(1'b1, 3'h1, 32'h2);
    bus(1'b0, 3'h1, 32'h0); chk(rd, 32'h2);
  endtask : t_regs

  task automatic t_thermal();
    en_want <= 1'b1;
    settle(6); chk(sw_on, 1'b1);
    t_hi <= 1'b1;
    settle(5); chk(sw_on, 1'b0);
    chk(st_n, 1'b0);
    chk(sense, 1'b1);
    chk(irq, 1'b0);
    bus(1'b0, 3'h2, 32'h0); chk(rd[1:0], 2'h3);
    bus(1'b1, 3'h4, 32'h1);
    settle(3); chk(irq, 1'b1);
    bus(1'b0, 3'h3, 32'h0); chk(rd[0], 1'b1);
    settle(3); chk(irq, 1'b0);
    t_hi <= 1'b0;
    settle(400); chk(sw_on, 1'b0);
    t_hys <= 1'b1;
    settle(6); chk(sw_on, 1'b0);
    latch_want <= 1'b0;
    settle(6); chk(sw_on, 1'b1);
    chk(st_n, 1'b1);
    chk(sense, 1'b1);
    output_voltage <= 1'b1;
    settle(4); chk(sense, 1'b0);
    t_hys <= 1'b0;
  endtask : t_thermal

  task automatic t_current();
    cur <= 1'b1;
    settle(150);
    cur <= 1'b0;
    settle(5); chk(sw_on, 1'b1);
    cur <= 1'b1;
    settle(190); chk(sw_on, 1'b1);
    settle(20); chk(sw_on, 1'b0);
    cur <= 1'b0;
    settle(400); chk(sw_on, 1'b1);
    bus(1'b1, 3'h0, 32'h1);
    cur <= 1'b1;
    settle(300); chk(sw_on, 1'b1);
    chk(regul, 1'b1);
    nrg <= 1'b1;
    settle(5); chk(sw_on, 1'b0);
    chk(st_n, 1'b0);
    nrg <= 1'b0;
    cur <= 1'b0;
    settle(400); chk(sw_on, 1'b1);
    bus(1'b1, 3'h0, 32'h0);
  endtask : t_current

  task automatic t_fold();
    stby <= 1'b1;
    settle(2);
    stby <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      settle(2); chk(half, 1'b0);
      nrg <= 1'b1;
      settle(2);
      nrg <= 1'b0;
      settle(100); chk(sw_on, 1'b0);
      settle(300); chk(sw_on, 1'b1);
    end
    chk(half, 1'b1);
    bus(1'b0, 3'h2, 32'h0); chk(rd[9:5], 5'h1d);
    en_want <= 1'b0;
    settle(4); chk(half, 1'b0);
    en_want <= 1'b1;
    settle(6);
    nrg <= 1'b1;
    settle(2);
    nrg <= 1'b0;
    stby <= 1'b1;
    settle(2);
    stby <= 1'b0;
    bus(1'b0, 3'h2, 32'h0); chk(rd[9:8], 2'h0);
    settle(300); chk(sw_on, 1'b1);
  endtask : t_fold

  task automatic t_supply();
    uv_r <= 1'b0;
    uv_f <= 1'b1;
    settle(5); chk(sw_on, 1'b0);
    uv_f <= 1'b0;
    uv_r <= 1'b1;
    settle(5); chk(sw_on, 1'b1);
    ld <= 1'b1;
    en_want <= 1'b0;
    settle(6); chk(sw_on, 1'b1);
    ld <= 1'b0;
    settle(6); chk(sw_on, 1'b0);
    rev <= 1'b1;
    select_bit_two <= 1'b1;
    settle(5); chk(sw_on, 1'b1);
    t_hi <= 1'b1;
    settle(6); chk(sw_on, 1'b1);
    chk(st_n, 1'b1);
    bus(1'b0, 3'h3, 32'h0); chk(rd, 32'hf);
  endtask : t_supply

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    settle(20);
    rst <= 1'b0;
    settle(1);
    t_regs();
    t_thermal();
    t_current();
    t_fold();
    t_supply();
    conclude();
  end

  // the whole run needs roughly 3500 cycles
  initial begin
    settle(20000);
    failures++;
    conclude();
  end
endmodule : test_sfp_fault_ctrl
